// ===== src/ibc_pkg.sv
/*
 * Shared constants and types for the interrupt-enable and backlight
 * configuration register bank.
 * Assumes a single 10 MHz clock and a two-wire serial host bus.
 */
package ibc_pkg;

    // Register offsets on the serial bus.
    localparam logic [7:0] REG_MODE = 8'h01;
    localparam logic [7:0] REG_FLAGS = 8'h02;
    localparam logic [7:0] REG_IEN = 8'h03;
    localparam logic [7:0] REG_CFG = 8'h04;

    // Mode register bit positions.
    localparam int MODE_INT_CFG = 6;
    localparam int MODE_AUTO = 1;

    // Source positions, shared by the flag and enable registers.
    localparam int NUM_SRC = 5;
    localparam int SRC_OVERLOAD = 4;
    localparam int SRC_THERMAL = 3;
    localparam int SRC_OVERVOLT = 2;
    localparam int SRC_LIGHT2 = 1;
    localparam int SRC_LIGHT1 = 0;

    // Configuration register field positions.
    localparam int CFG_SEL = 6;
    localparam int CFG_C2SEL = 5;
    localparam int CFG_BLV_LO = 3;
    localparam int CFG_LAW_LO = 1;
    localparam int CFG_FADE_OVERRIDE = 0;

    // Field encodings and reset values.
    localparam logic [1:0] BLV_OFF = 2'h3;
    localparam logic [1:0] LAW_LINEAR = 2'h0;
    localparam logic [1:0] LAW_SQUARE = 2'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Interrupt release time after a clear attempt.
    localparam int IRQ_HOLD_US = 50;
    localparam int CLK_FREQ_MHZ = 10;
    localparam int HOLD_W = 9;
    localparam logic [HOLD_W-1:0] IRQ_HOLD_CYC =
        HOLD_W'(IRQ_HOLD_US * CLK_FREQ_MHZ);
    localparam logic [HOLD_W-1:0] HOLD_ZERO = 9'h000;

    // Serial engine.
    localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2a; // Arbitrary value.
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_AACK = 3'h3,
        ST_RX = 3'h2,
        ST_RACK = 3'h6,
        ST_TX = 3'h7,
        ST_TACK = 3'h5
    } ibc_state_t;

    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } ibc_req_t;

    typedef struct packed {
        logic light_source_select;
        logic second_light_input_enable;
        logic sink_six_off;
        logic [1:0] brightness_level;
        logic backlight_off;
        logic dac_square;
        logic nonlinear_steps;
        logic cubic_profile_b;
        logic fade_override;
    } ibc_cfg_t;

endpackage : ibc_pkg

// ===== src/ibc_sync.sv
/*
 * Two-flop synchroniser for a group of asynchronous levels.
 * Assumes the inputs come from pins outside the ref_clk domain.
 */
`timescale 1ns/100ps
module ibc_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Levels.
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // The first stage feeds only the second one.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= meta_d;
            sync_out <= sync_d;
        end
    end

endmodule : ibc_sync

// ===== src/ibc_top.sv
/*
 * Interrupt enable, status flags and backlight configuration registers,
 * reached by a host over the two-wire serial bus.
 * Assumes scl, sda and all event and comparator pins are asynchronous.
 */
// Behaviour
// - Overload flag raises irq only if bit4
// - Thermal flag raises irq only if bit3
// - Overvoltage flag raises irq only if bit2
// - Second light flag raises irq if bit1
// - Main light flag raises irq if bit0
// - Bit6 picks light input driving backlight
// - Bit5 enables second input, sink six off
// - Level field: three levels, 11 is off
// - Level field reads back level in effect
// - Auto response overwrites level field
// - Law 00 linear, 01 square DAC
// - Law 10/11 square, two cubic profiles
// - Bit0 enables backlight fade override
// - Flags clear on write one only
// - Clear attempt drops irq 50 us optionally
`timescale 1ns/100ps
module ibc_top #(
    parameter logic [6:0] BUS_ADDR = ibc_pkg::BUS_ADDR_DEFAULT
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Serial host bus, sda is open drain.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Event sources, one bit per source.
    input wire logic [ibc_pkg::NUM_SRC-1:0] event_in,
    // Comparator levels for automatic response.
    input wire logic [1:0] main_light_input,
    input wire logic [1:0] second_light_input,
    // Results.
    output logic host_irq,
    output ibc_pkg::ibc_cfg_t cfg_out
);

    ////////////////////////////////////////////////////////////////////////
    // Synchronisers.

    logic [1:0] bus_s;
    logic [ibc_pkg::NUM_SRC+3:0] pin_s;
    logic scl_s;
    logic sda_s;
    logic [ibc_pkg::NUM_SRC-1:0] event_s;
    logic [1:0] main_s;
    logic [1:0] second_s;

    ibc_sync #(.W(2)) u_bus_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in({scl_in, sda_in}),
        .sync_out(bus_s)
    );

    ibc_sync #(.W(ibc_pkg::NUM_SRC + 4)) u_pin_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in({event_in, main_light_input, second_light_input}),
        .sync_out(pin_s)
    );

    always_comb begin
        scl_s = bus_s[1];
        sda_s = bus_s[0];
        event_s = pin_s[ibc_pkg::NUM_SRC+3:4];
        main_s = pin_s[3:2];
        second_s = pin_s[1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial engine.

    ibc_pkg::ibc_state_t st_q, st_d;
    logic scl_p_q, scl_p_d;
    logic sda_p_q, sda_p_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] ptr_q, ptr_d;
    logic ptr_phase_q, ptr_phase_d;
    logic rw_q, rw_d;
    logic oe_n_q, oe_n_d;
    logic [7:0] rdata;
    ibc_pkg::ibc_req_t req;
    logic scl_rise, scl_fall, start_c, stop_c;

    always_comb begin
        scl_rise = scl_s & ~scl_p_q;
        scl_fall = ~scl_s & scl_p_q;
        start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
        stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
        scl_p_d = scl_s;
        sda_p_d = sda_s;
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        ptr_phase_d = ptr_phase_q;
        rw_d = rw_q;
        oe_n_d = oe_n_q;
        req = '{wr: 1'b0, addr: ptr_q, data: sh_q};
        if (start_c) begin
            st_d = ibc_pkg::ST_ADDR;
            cnt_d = ibc_pkg::BIT_ZERO;
            oe_n_d = 1'b1;
        end else if (stop_c) begin
            st_d = ibc_pkg::ST_IDLE;
            oe_n_d = 1'b1;
        end else begin
            case (st_q)
                ibc_pkg::ST_ADDR, ibc_pkg::ST_RX: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_s};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == ibc_pkg::BYTE_BITS) begin
                        if (st_q == ibc_pkg::ST_ADDR) begin
                            if (sh_q[7:1] == BUS_ADDR) begin
                                rw_d = sh_q[0];
                                oe_n_d = 1'b0;
                                st_d = ibc_pkg::ST_AACK;
                            end else begin
                                st_d = ibc_pkg::ST_IDLE;
                            end
                        end else begin
                            oe_n_d = 1'b0;
                            st_d = ibc_pkg::ST_RACK;
                            if (ptr_phase_q) begin
                                ptr_d = sh_q;
                                ptr_phase_d = 1'b0;
                            end else begin
                                req.wr = 1'b1;
                                ptr_d = ptr_q + 8'h01;
                            end
                        end
                    end
                end
                ibc_pkg::ST_AACK, ibc_pkg::ST_RACK: begin
                    if (scl_fall) begin
                        cnt_d = ibc_pkg::BIT_ZERO;
                        if (st_q == ibc_pkg::ST_AACK && rw_q) begin
                            sh_d = rdata;
                            oe_n_d = rdata[7];
                            st_d = ibc_pkg::ST_TX;
                        end else begin
                            oe_n_d = 1'b1;
                            st_d = ibc_pkg::ST_RX;
                            if (st_q == ibc_pkg::ST_AACK) begin
                                ptr_phase_d = 1'b1;
                            end
                        end
                    end
                end
                ibc_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == ibc_pkg::LAST_BIT) begin
                            oe_n_d = 1'b1;
                            ptr_d = ptr_q + 8'h01;
                            st_d = ibc_pkg::ST_TACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_n_d = sh_q[6];
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                ibc_pkg::ST_TACK: begin
                    // A not-acknowledge ends the read burst.
                    if (scl_rise && sda_s) begin
                        st_d = ibc_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        sh_d = rdata;
                        oe_n_d = rdata[7];
                        cnt_d = ibc_pkg::BIT_ZERO;
                        st_d = ibc_pkg::ST_TX;
                    end
                end
                default: begin
                    oe_n_d = 1'b1;
                    st_d = ibc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= ibc_pkg::ST_IDLE;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            cnt_q <= ibc_pkg::BIT_ZERO;
            sh_q <= ibc_pkg::BYTE_ZERO;
            ptr_q <= ibc_pkg::BYTE_ZERO;
            ptr_phase_q <= 1'b0;
            rw_q <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            st_q <= st_d;
            scl_p_q <= scl_p_d;
            sda_p_q <= sda_p_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            ptr_phase_q <= ptr_phase_d;
            rw_q <= rw_d;
            oe_n_q <= oe_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    logic int_cfg_q, int_cfg_d;
    logic auto_q, auto_d;
    logic [ibc_pkg::NUM_SRC-1:0] flag_q, flag_d;
    logic [ibc_pkg::NUM_SRC-1:0] ien_q, ien_d;
    logic sel_q, sel_d;
    logic c2sel_q, c2sel_d;
    logic [1:0] blv_q, blv_d;
    logic [1:0] law_q, law_d;
    logic fade_override_q, fade_override_d;
    logic [ibc_pkg::HOLD_W-1:0] hold_q, hold_d;
    logic irq_d;
    ibc_pkg::ibc_cfg_t cfg_d;
    logic clr_hit;

    always_comb begin
        rdata = ibc_pkg::BYTE_ZERO;
        case (ptr_q)
            ibc_pkg::REG_MODE: begin
                rdata[ibc_pkg::MODE_INT_CFG] = int_cfg_q;
                rdata[ibc_pkg::MODE_AUTO] = auto_q;
            end
            ibc_pkg::REG_FLAGS: rdata[ibc_pkg::NUM_SRC-1:0] = flag_q;
            ibc_pkg::REG_IEN: rdata[ibc_pkg::NUM_SRC-1:0] = ien_q;
            ibc_pkg::REG_CFG: begin
                rdata[ibc_pkg::CFG_SEL] = sel_q;
                rdata[ibc_pkg::CFG_C2SEL] = c2sel_q;
                rdata[ibc_pkg::CFG_BLV_LO+:2] = blv_q;
                rdata[ibc_pkg::CFG_LAW_LO+:2] = law_q;
                rdata[ibc_pkg::CFG_FADE_OVERRIDE] = fade_override_q;
            end
            default: rdata = ibc_pkg::BYTE_ZERO;
        endcase
    end

    always_comb begin
        int_cfg_d = int_cfg_q;
        auto_d = auto_q;
        ien_d = ien_q;
        sel_d = sel_q;
        c2sel_d = c2sel_q;
        blv_d = blv_q;
        law_d = law_q;
        fade_override_d = fade_override_q;
        clr_hit = req.wr && req.addr == ibc_pkg::REG_FLAGS;
        flag_d = flag_q;
        if (clr_hit) begin
            flag_d = flag_q & ~req.data[ibc_pkg::NUM_SRC-1:0];
        end
        // Setting beats clearing so an event in the clear cycle is kept.
        flag_d = flag_d | event_s;
        if (req.wr) begin
            case (req.addr)
                ibc_pkg::REG_MODE: begin
                    int_cfg_d = req.data[ibc_pkg::MODE_INT_CFG];
                    auto_d = req.data[ibc_pkg::MODE_AUTO];
                end
                ibc_pkg::REG_IEN: ien_d = req.data[ibc_pkg::NUM_SRC-1:0];
                ibc_pkg::REG_CFG: begin
                    sel_d = req.data[ibc_pkg::CFG_SEL];
                    c2sel_d = req.data[ibc_pkg::CFG_C2SEL];
                    blv_d = req.data[ibc_pkg::CFG_BLV_LO+:2];
                    law_d = req.data[ibc_pkg::CFG_LAW_LO+:2];
                    fade_override_d = req.data[ibc_pkg::CFG_FADE_OVERRIDE];
                end
                default: ;
            endcase
        end
        // Hardware tracking overrides any level software forced.
        if (auto_q) begin
            blv_d = (sel_q && c2sel_q) ? second_s : main_s;
        end
        hold_d = hold_q;
        if (clr_hit && int_cfg_q) begin
            hold_d = ibc_pkg::IRQ_HOLD_CYC;
        end else if (hold_q != ibc_pkg::HOLD_ZERO) begin
            hold_d = hold_q - 9'h001;
        end
        // Without the release window the line simply stays asserted.
        irq_d = (|(flag_q & ien_q)) && hold_q == ibc_pkg::HOLD_ZERO;
        cfg_d.light_source_select = sel_q;
        cfg_d.second_light_input_enable = c2sel_q;
        cfg_d.sink_six_off = c2sel_q;
        cfg_d.brightness_level = blv_q;
        cfg_d.backlight_off = blv_q == ibc_pkg::BLV_OFF;
        cfg_d.dac_square = law_q != ibc_pkg::LAW_LINEAR;
        cfg_d.nonlinear_steps = law_q[1];
        cfg_d.cubic_profile_b = law_q[1] & law_q[0];
        cfg_d.fade_override = fade_override_q;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            int_cfg_q <= 1'b0;
            auto_q <= 1'b0;
            flag_q <= '0;
            ien_q <= '0;
            sel_q <= 1'b0;
            c2sel_q <= 1'b0;
            blv_q <= 2'h0;
            law_q <= ibc_pkg::LAW_LINEAR;
            fade_override_q <= 1'b0;
            hold_q <= ibc_pkg::HOLD_ZERO;
            host_irq <= 1'b0;
            cfg_out <= '0;
            sda_out <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            int_cfg_q <= int_cfg_d;
            auto_q <= auto_d;
            flag_q <= flag_d;
            ien_q <= ien_d;
            sel_q <= sel_d;
            c2sel_q <= c2sel_d;
            blv_q <= blv_d;
            law_q <= law_d;
            fade_override_q <= fade_override_d;
            hold_q <= hold_d;
            host_irq <= irq_d;
            cfg_out <= cfg_d;
            sda_out <= 1'b0;
            sda_oe_n <= oe_n_q;
        end
    end

endmodule : ibc_top

// ===== verif/ibc_asserts.sv
/* Concurrent checks on the ports of the register bank top.
   Assumes a host that keeps scl low for six cycles per bit. */
`timescale 1ns/100ps
module ibc_asserts (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset,
    // Serial bus.
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // Sources and results.
    input wire logic [ibc_pkg::NUM_SRC-1:0] event_in,
    input wire logic [1:0] main_light_input,
    input wire logic [1:0] second_light_input,
    input wire logic host_irq,
    input wire ibc_pkg::ibc_cfg_t cfg_out
);
    // Fields that only a bus write may change.
    logic [5:0] sw_fields;
    assign sw_fields = {cfg_out.light_source_select,
        cfg_out.second_light_input_enable, cfg_out.dac_square,
        cfg_out.nonlinear_steps, cfg_out.cubic_profile_b,
        cfg_out.fade_override};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    //////////////////////////////////////////////////////////////////////
    reset_quiet_a: assert property (disable iff (1'b0)
        reset |=> !host_irq && cfg_out == 10'h000 && sda_oe_n)
        else $error("outputs not cleared by reset");
    sda_zero_a: assert property (!sda_out)
        else $error("sda_out driven high");
    ack_timing_a: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("sda changed while scl high");
    sw_fields_a: assert property ($changed(sw_fields) |-> !scl_in)
        else $error("config field changed outside a bus write");
    sink_off_a: assert property (
        cfg_out.sink_six_off == cfg_out.second_light_input_enable)
        else $error("sink six not tied to second input enable");
    level_off_a: assert property (
        cfg_out.backlight_off == (cfg_out.brightness_level == 2'h3))
        else $error("backlight off does not match level code");
    law_square_a: assert property (
        cfg_out.nonlinear_steps |-> cfg_out.dac_square)
        else $error("nonlinear steps without square law");
    cubic_law_a: assert property (
        cfg_out.cubic_profile_b |-> cfg_out.nonlinear_steps)
        else $error("cubic profile without nonlinear steps");
    irq_fall_a: assert property ($fell(host_irq) |-> !scl_in)
        else $error("irq dropped without a bus write");
endmodule : ibc_asserts

bind ibc_top ibc_asserts asserts_u (.ref_clk(ref_clk), .reset(reset),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .event_in(event_in),
    .main_light_input(main_light_input),
    .second_light_input(second_light_input), .host_irq(host_irq),
    .cfg_out(cfg_out));

// ===== verif/ibc_host_model.sv
/* Host side of the two-wire register bus: start, stop and byte tasks.
   Assumes the bench resolves sda from all drivers with a pull-up. */
`timescale 1ns/100ps
module ibc_host_model (
    // Clock.
    input wire logic ref_clk,
    // Bus lines.
    input wire logic sda_level,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    //////////////////////////////////////////////////////////////////////
    // Six low cycles, since the device answers four cycles after a fall.
    task automatic bit_cycle(input logic b, output logic r);
        @(posedge ref_clk) sda_low <= !b;
        repeat (5) @(posedge ref_clk);
        scl <= 1'b1;
        repeat (2) @(posedge ref_clk);
        r = sda_level;
        scl <= 1'b0;
    endtask : bit_cycle
    task automatic xbyte(input logic [7:0] tx, input logic mack,
                         output logic [7:0] rx, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(tx[i], b);
            rx[i] = b;
        end
        bit_cycle(mack, ack);
    endtask : xbyte
    task automatic start_cond();
        @(posedge ref_clk) sda_low <= 1'b0;
        repeat (5) @(posedge ref_clk);
        scl <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sda_low <= 1'b1;
        repeat (4) @(posedge ref_clk);
        scl <= 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        @(posedge ref_clk) sda_low <= 1'b1;
        repeat (5) @(posedge ref_clk);
        scl <= 1'b1;
        repeat (4) @(posedge ref_clk);
        sda_low <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : stop_cond
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] addr,
                             input logic [7:0] data, output logic acked);
        logic [7:0] rx;
        logic a0, a1, a2;
        start_cond();
        xbyte({dev, 1'b0}, 1'b1, rx, a0);
        xbyte(addr, 1'b1, rx, a1);
        xbyte(data, 1'b1, rx, a2);
        stop_cond();
        acked = !(a0 | a1 | a2);
    endtask : write_reg
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        logic [7:0] rx;
        logic a;
        start_cond();
        xbyte({ibc_pkg::BUS_ADDR_DEFAULT, 1'b0}, 1'b1, rx, a);
        xbyte(addr, 1'b1, rx, a);
        start_cond();
        xbyte({ibc_pkg::BUS_ADDR_DEFAULT, 1'b1}, 1'b1, rx, a);
        xbyte(8'hff, 1'b1, data, a);
        stop_cond();
    endtask : read_reg
endmodule : ibc_host_model

// ===== verif/testbench.sv
/* Self-checking bench for the register bank top.
   Assumes the host model above and the package constants. */
`timescale 1ns/100ps
module testbench;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] event_in = 5'h00;
    logic [1:0] main_light_input = 2'h0;
    logic [1:0] second_light_input = 2'h0;
    logic scl, sda_low, sda_level, sda_out, sda_oe_n, host_irq, ok;
    ibc_pkg::ibc_cfg_t cfg_out;
    logic [7:0] rd, bit_i, v;
    int failures = 0;
    int checks = 0;
    assign sda_level = !sda_low && (sda_oe_n || sda_out);
    always #50 ref_clk = ~ref_clk;
    ibc_top dut_u (.ref_clk(ref_clk), .reset(reset), .scl_in(scl),
        .sda_in(sda_level), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .event_in(event_in), .main_light_input(main_light_input),
        .second_light_input(second_light_input), .host_irq(host_irq),
        .cfg_out(cfg_out));
    ibc_host_model host_u (.ref_clk(ref_clk), .sda_level(sda_level),
        .scl(scl), .sda_low(sda_low));
    //////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [9:0] e,
                       input logic [9:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic irq_is(input logic e);
        chk("host_irq", {9'h000, e}, {9'h000, host_irq});
    endtask : irq_is
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.write_reg(ibc_pkg::BUS_ADDR_DEFAULT, a, d, ok);
        chk("ack", 10'h001, {9'h000, ok});
    endtask : wr
    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [7:0] e);
        host_u.read_reg(a, rd);
        chk(what, {2'h0, e}, {2'h0, rd});
    endtask : rdchk
    function automatic logic [9:0] exp_cfg(input logic [7:0] c);
        exp_cfg = {c[6], c[5], c[5], c[4:3], &c[4:3], |c[2:1], c[2],
            &c[2:1], c[0]};
    endfunction : exp_cfg
    task automatic print_verdict();
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    // The bus is slow, so the limit allows about forty thousand cycles.
    initial begin
        #4000000;
        failures++;
        $display("ERROR watchdog expected done seen timeout");
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(posedge ref_clk);
        irq_is(1'b0);
        chk("cfg_out", 10'h000, cfg_out);
        rdchk("ien", 8'h03, 8'h00);
        rdchk("unmapped", 8'h07, 8'h00);
        host_u.write_reg(~ibc_pkg::BUS_ADDR_DEFAULT, 8'h03, 8'h1f, ok);
        chk("foreign ack", 10'h000, {9'h000, ok});
        for (int i = 0; i < 5; i++) begin
            bit_i = 8'h01 << i;
            event_in <= bit_i[4:0];
            repeat (5) @(posedge ref_clk);
            event_in <= 5'h00;
            repeat (5) @(posedge ref_clk);
            irq_is(1'b0);
            rdchk("flag", 8'h02, bit_i);
            wr(8'h03, bit_i);
            irq_is(1'b1);
            wr(8'h02, 8'h00);
            rdchk("flag kept", 8'h02, bit_i);
            wr(8'h03, ~bit_i & 8'h1f);
            irq_is(1'b0);
            wr(8'h02, bit_i);
            rdchk("flag clear", 8'h02, 8'h00);
            wr(8'h03, 8'h00);
        end
        wr(8'h03, 8'hff);
        rdchk("ien reserved", 8'h03, 8'h1f);
        wr(8'h01, 8'h40);
        event_in <= 5'h10;
        repeat (5) @(posedge ref_clk);
        irq_is(1'b1);
        wr(8'h02, 8'h10);
        irq_is(1'b0);
        repeat (400) @(posedge ref_clk);
        irq_is(1'b0);
        repeat (120) @(posedge ref_clk);
        irq_is(1'b1);
        wr(8'h01, 8'h00);
        wr(8'h02, 8'h10);
        irq_is(1'b1);
        event_in <= 5'h00;
        wr(8'h02, 8'h10);
        irq_is(1'b0);
        for (int k = 0; k < 4; k++) begin
            v = {1'b1, k[1], k[0], k[1:0], k[1:0], k[0]};
            wr(8'h04, v);
            rdchk("cfg", 8'h04, v & 8'h7f);
            chk("cfg_out", exp_cfg(v), cfg_out);
        end
        main_light_input <= 2'h2;
        second_light_input <= 2'h1;
        wr(8'h01, 8'h02);
        wr(8'h04, 8'h60);
        rdchk("auto level", 8'h04, 8'h68);
        wr(8'h04, 8'h20);
        rdchk("auto level", 8'h04, 8'h30);
        chk("cfg_out", exp_cfg(8'h30), cfg_out);
        print_verdict();
    end
endmodule : testbench
